// ### design/dap_pkg.sv
// Shared constants, types and helpers for the dual address port block.
// Assumes an 8-bit register port with a 16-bit address and 8-bit pins.
package dap_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int BUS_ADDR_W = 24;

  // Register offsets as printed; the register port is byte addressed.
  localparam logic [ADDR_W-1:0] FIRST_PORT_DATA = 16'h0001;
  localparam logic [ADDR_W-1:0] FIRST_PORT_DIRECTION = 16'h0004;
  localparam logic [ADDR_W-1:0] FIRST_PORT_FUNCTION = 16'h0005;
  localparam logic [ADDR_W-1:0] SECOND_PORT_DATA = 16'h0006;
  localparam logic [ADDR_W-1:0] SECOND_PORT_DIRECTION = 16'h0008;
  localparam logic [ADDR_W-1:0] SECOND_PORT_FUNCTION = 16'h0009;

  // Reset values
  localparam logic [DATA_W-1:0] FIRST_LATCH_RST = 8'h00;
  localparam logic [DATA_W-1:0] SECOND_LATCH_RST = 8'hff;
  localparam logic [DATA_W-1:0] DIR_RST = 8'h00;
  localparam logic [DATA_W-1:0] FN_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] PIN_RELEASED = 8'hff;

  // Address byte positions on the external bus
  localparam int LOW_BYTE_LSB = 0;
  localparam int MIDDLE_BYTE_LSB = 8;
  localparam int HIGH_BYTE_LSB = 16;

  typedef enum logic [1:0] {
    MODE_INPUT,
    MODE_OUTPUT,
    MODE_ALT_A,
    MODE_ALT_B
  } dap_mode_type;

  // Function bit is the upper half of the pair, direction bit the lower.
  function automatic dap_mode_type dap_mode(input logic fn, input logic dir);
    dap_mode_type m;
    m = MODE_INPUT;
    unique case ({fn, dir})
      2'b00: m = MODE_INPUT;
      2'b01: m = MODE_OUTPUT;
      2'b10: m = MODE_ALT_A;
      2'b11: m = MODE_ALT_B;
    endcase
    return m;
  endfunction : dap_mode

  function automatic logic dap_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
    return addr == off;
  endfunction : dap_hit

endpackage : dap_pkg

// ### design/dap_sync2.sv
// Two-flop synchroniser for one 8-bit group of pin levels.
// Assumes the pins change asynchronously to clk_in.
`timescale 1ns/10ps
module dap_sync2 (
  input wire logic clk_in,                            // System clock
  input wire logic rst_in,                            // Synchronous reset, high
  input wire logic [dap_pkg::DATA_W-1:0] async_in,    // Raw pin levels
  output logic [dap_pkg::DATA_W-1:0] sync_out         // Levels, two flops later
);

  logic [dap_pkg::DATA_W-1:0] meta_q;
  logic [dap_pkg::DATA_W-1:0] sync_q;

  // The first stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= dap_pkg::BYTE_ZERO;
      sync_q <= dap_pkg::BYTE_ZERO;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : dap_sync2

// ### design/dap_pin_mux.sv
// Per-pin function selector for one 8-pin port.
// Assumes the alternate sources come from logic on the same clock.
`timescale 1ns/10ps
module dap_pin_mux (
  input wire logic clk_in,                            // System clock
  input wire logic rst_in,                            // Synchronous reset, high
  input wire logic [dap_pkg::DATA_W-1:0] fn_in,       // Function bits
  input wire logic [dap_pkg::DATA_W-1:0] dir_in,      // Direction bits
  input wire logic [dap_pkg::DATA_W-1:0] latch_in,    // Output latch
  input wire logic [dap_pkg::DATA_W-1:0] alt_a_in,    // Pair 10 source
  input wire logic alt_a_drive_in,                    // Pair 10 drives when high
  input wire logic [dap_pkg::DATA_W-1:0] alt_b_in,    // Pair 11 source
  output logic [dap_pkg::DATA_W-1:0] pin_out,         // Pin output level
  output logic [dap_pkg::DATA_W-1:0] pin_oe_n_out     // Pin enable, low drives
);

  logic [dap_pkg::DATA_W-1:0] pin_d;
  logic [dap_pkg::DATA_W-1:0] pin_q;
  logic [dap_pkg::DATA_W-1:0] oe_n_d;
  logic [dap_pkg::DATA_W-1:0] oe_n_q;

  always_comb begin
    pin_d = dap_pkg::BYTE_ZERO;
    oe_n_d = dap_pkg::PIN_RELEASED;
    for (int i = 0; i < dap_pkg::DATA_W; i++) begin
      unique case (dap_pkg::dap_mode(fn_in[i], dir_in[i]))
        dap_pkg::MODE_INPUT: begin
          pin_d[i] = latch_in[i];
        end
        dap_pkg::MODE_OUTPUT: begin
          pin_d[i] = latch_in[i];
          oe_n_d[i] = 1'b0;
        end
        dap_pkg::MODE_ALT_A: begin
          pin_d[i] = alt_a_in[i];
          oe_n_d[i] = ~alt_a_drive_in;
        end
        dap_pkg::MODE_ALT_B: begin
          pin_d[i] = alt_b_in[i];
          oe_n_d[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_q <= dap_pkg::BYTE_ZERO;
      oe_n_q <= dap_pkg::PIN_RELEASED;
    end else begin
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_out = pin_q;
  assign pin_oe_n_out = oe_n_q;

endmodule : dap_pin_mux

// ### design/dap_top.sv
// Two 8-pin ports that serve as general I/O or as external address lines.
// Assumes a register master on clk_in and an external bus controller that
// supplies the address and the upper data byte on the same clock.
//
// How it works
// - First port: eight pins, per-bit direction/function
// - Reset clears first port latch, direction, function
// - First port direction/function write-only, no read-modify-write
// - Second port: eight pins, per-bit direction/function
// - Reset sets second latch ones, clears direction/function
// - Second port direction/function write-only, no read-modify-write
// - Second port function without direction drives low address byte
`timescale 1ns/10ps
module dap_top (
  input wire logic clk_in,                                // 20 MHz system clock
  input wire logic rst_in,                                // Synchronous reset, high
  input wire logic [dap_pkg::ADDR_W-1:0] reg_addr_in,     // Register address
  input wire logic [dap_pkg::DATA_W-1:0] reg_wdata_in,    // Register write data
  input wire logic reg_wr_in,                             // Write strobe
  input wire logic reg_rd_in,                             // Read strobe
  output logic [dap_pkg::DATA_W-1:0] reg_rdata_out,       // Read data, next cycle
  input wire logic [dap_pkg::BUS_ADDR_W-1:0] bus_addr_in, // External address
  input wire logic [dap_pkg::DATA_W-1:0] bus_ad_wdata_in, // Upper data byte to drive
  input wire logic bus_ad_drive_in,                       // Drive upper data byte
  output logic [dap_pkg::DATA_W-1:0] bus_ad_rdata_out,    // Upper data byte seen
  input wire logic [dap_pkg::DATA_W-1:0] first_pin_in,    // First port pin levels
  output logic [dap_pkg::DATA_W-1:0] first_pin_out,       // First port pin drive
  output logic [dap_pkg::DATA_W-1:0] first_pin_oe_n_out,  // First port enable, low
  input wire logic [dap_pkg::DATA_W-1:0] second_pin_in,   // Second port pin levels
  output logic [dap_pkg::DATA_W-1:0] second_pin_out,      // Second port pin drive
  output logic [dap_pkg::DATA_W-1:0] second_pin_oe_n_out  // Second port enable, low
);

  logic [dap_pkg::DATA_W-1:0] first_lat_d;
  logic [dap_pkg::DATA_W-1:0] first_lat_q;
  logic [dap_pkg::DATA_W-1:0] first_dir_d;
  logic [dap_pkg::DATA_W-1:0] first_dir_q;
  logic [dap_pkg::DATA_W-1:0] first_fn_d;
  logic [dap_pkg::DATA_W-1:0] first_fn_q;
  logic [dap_pkg::DATA_W-1:0] second_lat_d;
  logic [dap_pkg::DATA_W-1:0] second_lat_q;
  logic [dap_pkg::DATA_W-1:0] second_dir_d;
  logic [dap_pkg::DATA_W-1:0] second_dir_q;
  logic [dap_pkg::DATA_W-1:0] second_fn_d;
  logic [dap_pkg::DATA_W-1:0] second_fn_q;
  logic [dap_pkg::DATA_W-1:0] rdata_d;
  logic [dap_pkg::DATA_W-1:0] rdata_q;
  logic [dap_pkg::DATA_W-1:0] first_lvl;
  logic [dap_pkg::DATA_W-1:0] second_lvl;

  // Pin levels pass two flops before any register read looks at them
  dap_sync2 u_first_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(first_pin_in),
    .sync_out(first_lvl)
  );

  dap_sync2 u_second_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(second_pin_in),
    .sync_out(second_lvl)
  );

  // Register writes; each direction/function bit stays its own pin's
  always_comb begin
    first_lat_d = first_lat_q;
    first_dir_d = first_dir_q;
    first_fn_d = first_fn_q;
    second_lat_d = second_lat_q;
    second_dir_d = second_dir_q;
    second_fn_d = second_fn_q;
    if (reg_wr_in) begin
      if (dap_pkg::dap_hit(reg_addr_in, dap_pkg::FIRST_PORT_DATA)) begin
        first_lat_d = reg_wdata_in;
      end
      if (dap_pkg::dap_hit(reg_addr_in, dap_pkg::FIRST_PORT_DIRECTION)) begin
        first_dir_d = reg_wdata_in;
      end
      if (dap_pkg::dap_hit(reg_addr_in, dap_pkg::FIRST_PORT_FUNCTION)) begin
        first_fn_d = reg_wdata_in;
      end
      if (dap_pkg::dap_hit(reg_addr_in, dap_pkg::SECOND_PORT_DATA)) begin
        second_lat_d = reg_wdata_in;
      end
      if (dap_pkg::dap_hit(reg_addr_in, dap_pkg::SECOND_PORT_DIRECTION)) begin
        second_dir_d = reg_wdata_in;
      end
      if (dap_pkg::dap_hit(reg_addr_in, dap_pkg::SECOND_PORT_FUNCTION)) begin
        second_fn_d = reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      first_lat_q <= dap_pkg::FIRST_LATCH_RST;
      first_dir_q <= dap_pkg::DIR_RST;
      first_fn_q <= dap_pkg::FN_RST;
      second_lat_q <= dap_pkg::SECOND_LATCH_RST;
      second_dir_q <= dap_pkg::DIR_RST;
      second_fn_q <= dap_pkg::FN_RST;
    end else begin
      first_lat_q <= first_lat_d;
      first_dir_q <= first_dir_d;
      first_fn_q <= first_fn_d;
      second_lat_q <= second_lat_d;
      second_dir_q <= second_dir_d;
      second_fn_q <= second_fn_d;
    end
  end

  // Reads: data registers show the pins, not the latch. Direction and
  // function read as zero, so a read-modify-write would wipe them.
  always_comb begin
    rdata_d = dap_pkg::BYTE_ZERO;
    if (reg_rd_in) begin
      if (dap_pkg::dap_hit(reg_addr_in, dap_pkg::FIRST_PORT_DATA)) begin
        rdata_d = first_lvl;
      end else if (dap_pkg::dap_hit(reg_addr_in, dap_pkg::SECOND_PORT_DATA)) begin
        rdata_d = second_lvl;
      end else begin
        rdata_d = dap_pkg::BYTE_ZERO;
      end
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= dap_pkg::BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign bus_ad_rdata_out = first_lvl;

  // First port: pair 10 is the muxed upper data byte, 11 the middle address byte
  dap_pin_mux u_first_mux (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .fn_in(first_fn_q),
    .dir_in(first_dir_q),
    .latch_in(first_lat_q),
    .alt_a_in(bus_ad_wdata_in),
    .alt_a_drive_in(bus_ad_drive_in),
    .alt_b_in(bus_addr_in[dap_pkg::MIDDLE_BYTE_LSB +: dap_pkg::DATA_W]),
    .pin_out(first_pin_out),
    .pin_oe_n_out(first_pin_oe_n_out)
  );

  // Second port: pair 10 is the low address byte, 11 the high one. Setting
  // function before direction briefly drives the low byte, as software expects.
  dap_pin_mux u_second_mux (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .fn_in(second_fn_q),
    .dir_in(second_dir_q),
    .latch_in(second_lat_q),
    .alt_a_in(bus_addr_in[dap_pkg::LOW_BYTE_LSB +: dap_pkg::DATA_W]),
    .alt_a_drive_in(1'b1),
    .alt_b_in(bus_addr_in[dap_pkg::HIGH_BYTE_LSB +: dap_pkg::DATA_W]),
    .pin_out(second_pin_out),
    .pin_oe_n_out(second_pin_oe_n_out)
  );

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking

  sequence s_wr_at(logic [dap_pkg::ADDR_W-1:0] off);
    reg_wr_in && (reg_addr_in == off);
  endsequence

  sequence s_rd_at(logic [dap_pkg::ADDR_W-1:0] off);
    reg_rd_in && (reg_addr_in == off);
  endsequence

  property p_first_dir_write;
    disable iff (rst_in)
    s_wr_at(dap_pkg::FIRST_PORT_DIRECTION) |=> first_dir_q == $past(reg_wdata_in);
  endproperty
  a_first_dir_write: assert property (p_first_dir_write)
    else $error("first port direction write not taken");

  property p_first_reset;
    rst_in |=> (first_lat_q == dap_pkg::FIRST_LATCH_RST) &&
      (first_dir_q == dap_pkg::DIR_RST) && (first_fn_q == dap_pkg::FN_RST) ##1
      (first_pin_oe_n_out == dap_pkg::PIN_RELEASED) || rst_in;
  endproperty
  a_first_reset: assert property (p_first_reset)
    else $error("first port not cleared to inputs by reset");

  property p_first_modes;
    disable iff (rst_in)
    1'b1 |=> (((first_pin_out ^
      $past(bus_addr_in[dap_pkg::MIDDLE_BYTE_LSB +: dap_pkg::DATA_W])) &
      $past(first_fn_q) & $past(first_dir_q)) == dap_pkg::BYTE_ZERO) &&
      (((first_pin_out ^ $past(bus_ad_wdata_in)) &
      $past(first_fn_q) & ~$past(first_dir_q)) == dap_pkg::BYTE_ZERO);
  endproperty
  a_first_modes: assert property (p_first_modes)
    else $error("first port alternate pin shows wrong source");

  property p_first_cfg_reads_zero;
    disable iff (rst_in)
    (s_rd_at(dap_pkg::FIRST_PORT_DIRECTION) or s_rd_at(dap_pkg::FIRST_PORT_FUNCTION))
      |=> reg_rdata_out == dap_pkg::BYTE_ZERO;
  endproperty
  a_first_cfg_reads_zero: assert property (p_first_cfg_reads_zero)
    else $error("first port config register readable");

  property p_second_fn_write;
    disable iff (rst_in)
    s_wr_at(dap_pkg::SECOND_PORT_FUNCTION) |=> second_fn_q == $past(reg_wdata_in);
  endproperty
  a_second_fn_write: assert property (p_second_fn_write)
    else $error("second port function write not taken");

  property p_second_reset;
    rst_in |=> (second_lat_q == dap_pkg::SECOND_LATCH_RST) &&
      (second_dir_q == dap_pkg::DIR_RST) && (second_fn_q == dap_pkg::FN_RST);
  endproperty
  a_second_reset: assert property (p_second_reset)
    else $error("second port reset values wrong");

  property p_second_high_byte;
    disable iff (rst_in)
    1'b1 |=> (((second_pin_out ^
      $past(bus_addr_in[dap_pkg::HIGH_BYTE_LSB +: dap_pkg::DATA_W])) &
      $past(second_fn_q) & $past(second_dir_q)) == dap_pkg::BYTE_ZERO) &&
      ((second_pin_oe_n_out & $past(second_fn_q)) == dap_pkg::BYTE_ZERO);
  endproperty
  a_second_high_byte: assert property (p_second_high_byte)
    else $error("second port high address byte not driven");

  property p_second_cfg_reads_zero;
    disable iff (rst_in)
    (s_rd_at(dap_pkg::SECOND_PORT_DIRECTION) or s_rd_at(dap_pkg::SECOND_PORT_FUNCTION))
      |=> reg_rdata_out == dap_pkg::BYTE_ZERO;
  endproperty
  a_second_cfg_reads_zero: assert property (p_second_cfg_reads_zero)
    else $error("second port config register readable");

  property p_fn_before_dir;
    disable iff (rst_in)
    s_wr_at(dap_pkg::SECOND_PORT_FUNCTION) ##0 (second_dir_q == dap_pkg::DIR_RST)
      ##1 (second_dir_q == dap_pkg::DIR_RST) |=>
      ((second_pin_out ^ $past(bus_addr_in[dap_pkg::LOW_BYTE_LSB +: dap_pkg::DATA_W])) &
      $past(second_fn_q)) == dap_pkg::BYTE_ZERO;
  endproperty
  a_fn_before_dir: assert property (p_fn_before_dir)
    else $error("low address byte not driven before direction set");

  property p_data_read;
    disable iff (rst_in)
    s_rd_at(dap_pkg::FIRST_PORT_DATA) |=> reg_rdata_out == $past(first_lvl);
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("first port data read not pin levels");

  property p_latch_drive;
    disable iff (rst_in)
    1'b1 |=> (((first_pin_out ^ $past(first_lat_q)) &
      $past(first_dir_q) & ~$past(first_fn_q)) == dap_pkg::BYTE_ZERO) &&
      ((~first_pin_oe_n_out & ~($past(first_fn_q) | $past(first_dir_q))) ==
      dap_pkg::BYTE_ZERO);
  endproperty
  a_latch_drive: assert property (p_latch_drive)
    else $error("latch drive or input release wrong");

  property p_first_fn_write;
    disable iff (rst_in)
    s_wr_at(dap_pkg::FIRST_PORT_FUNCTION) |=> first_fn_q == $past(reg_wdata_in);
  endproperty
  a_first_fn_write: assert property (p_first_fn_write)
    else $error("first port function write not taken");

  property p_second_dir_write;
    disable iff (rst_in)
    s_wr_at(dap_pkg::SECOND_PORT_DIRECTION) |=> second_dir_q == $past(reg_wdata_in);
  endproperty
  a_second_dir_write: assert property (p_second_dir_write)
    else $error("second port direction write not taken");

  // Every second-port pin must be released right after reset
  property p_second_reset_pins;
    rst_in |=> second_pin_oe_n_out == dap_pkg::PIN_RELEASED;
  endproperty
  a_second_reset_pins: assert property (p_second_reset_pins)
    else $error("second port pins not released by reset");

  property p_second_data_read;
    disable iff (rst_in)
    s_rd_at(dap_pkg::SECOND_PORT_DATA) |=> reg_rdata_out == $past(second_lvl);
  endproperty
  a_second_data_read: assert property (p_second_data_read)
    else $error("second port data read not pin levels");

  // Stale read data would look like a second answer to the master
  property p_rdata_idle;
    disable iff (rst_in)
    !reg_rd_in |=> reg_rdata_out == dap_pkg::BYTE_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside the answer cycle");

endmodule : dap_top

// ### tb/dap_ext_bus_model.sv
// External memory and peripheral side of one 8-pin port, seen at the pads.
// Assumes the design drives a pad only while its enable is low.
`timescale 1ns/10ps
module dap_ext_bus_model (
  input wire logic clk_in,                               // System clock
  input wire logic rst_in,                               // Synchronous reset, high
  input wire logic [dap_pkg::DATA_W-1:0] pin_drv_in,     // Design pad drive value
  input wire logic [dap_pkg::DATA_W-1:0] oe_n_in,        // Design pad enable, low drives
  input wire logic ext_en_in,                            // Far side drives released pads
  input wire logic [dap_pkg::DATA_W-1:0] ext_val_in,     // Far side drive value
  output logic [dap_pkg::DATA_W-1:0] pin_lvl_out         // Resolved pad levels
);
  logic [dap_pkg::DATA_W-1:0] churn_q;

  // No pull-ups here: a floating pad must not settle to a lucky constant
  always_ff @(posedge clk_in) begin
    churn_q <= rst_in ? 8'h55 : ~churn_q;
  end

  always_comb begin
    for (int i = 0; i < dap_pkg::DATA_W; i++) begin
      if (!oe_n_in[i]) pin_lvl_out[i] = pin_drv_in[i];
      else if (ext_en_in) pin_lvl_out[i] = ext_val_in[i];
      else pin_lvl_out[i] = churn_q[i];
    end
  end
endmodule : dap_ext_bus_model

// ### tb/dap_top_bench.sv
// Self-checking bench for the dual address port block.
// Assumes a single 20 MHz clock and the plain register port of the design.
`timescale 1ns/10ps
module dap_top_bench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [23:0] bus_addr_in = 24'h13_579b;
  logic [7:0] bus_ad_wdata_in = 8'he4;
  logic bus_ad_drive_in = 1'b0;
  logic [7:0] bus_ad_rdata_out;
  logic [7:0] fst_lvl, fst_drv, fst_oe_n, snd_lvl, snd_drv, snd_oe_n;
  logic [7:0] ext1 = 8'h5a;
  logic [7:0] ext2 = 8'ha5;
  logic [7:0] lat1, lat2;
  logic [7:0] fn_tab [4] = '{8'h00, 8'hff, 8'hff, 8'hcc};
  logic [7:0] dir_tab [4] = '{8'hff, 8'h00, 8'hff, 8'haa};
  int fail_count = 0;
  int n_checks = 0;

  always #25 clk_in = ~clk_in;

  dap_top uut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .bus_addr_in(bus_addr_in),
    .bus_ad_wdata_in(bus_ad_wdata_in), .bus_ad_drive_in(bus_ad_drive_in),
    .bus_ad_rdata_out(bus_ad_rdata_out), .first_pin_in(fst_lvl), .first_pin_out(fst_drv),
    .first_pin_oe_n_out(fst_oe_n), .second_pin_in(snd_lvl), .second_pin_out(snd_drv),
    .second_pin_oe_n_out(snd_oe_n));

  dap_ext_bus_model far1 (.clk_in(clk_in), .rst_in(rst_in), .pin_drv_in(fst_drv),
    .oe_n_in(fst_oe_n), .ext_en_in(1'b1), .ext_val_in(ext1), .pin_lvl_out(fst_lvl));
  dap_ext_bus_model far2 (.clk_in(clk_in), .rst_in(rst_in), .pin_drv_in(snd_drv),
    .oe_n_in(snd_oe_n), .ext_en_in(1'b1), .ext_val_in(ext2), .pin_lvl_out(snd_lvl));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, then fall back to zero
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
    @(posedge clk_in);
    #1 chk(reg_rdata_out, 8'h00);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : settle

  // Bench's own view of one port: {enable_n, value} for each pin pair
  function automatic logic [15:0] exp_pins(input logic port2, input logic [7:0] fn,
                                           input logic [7:0] dir, input logic [7:0] lat);
    logic [7:0] oe;
    logic [7:0] v;
    oe = 8'h00;
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      case ({fn[i], dir[i]})
        2'b00: oe[i] = 1'b1;
        2'b01: v[i] = lat[i];
        2'b10: begin
          v[i] = port2 ? bus_addr_in[i] : bus_ad_wdata_in[i];
          oe[i] = port2 ? 1'b0 : !bus_ad_drive_in;
        end
        default: v[i] = port2 ? bus_addr_in[16+i] : bus_addr_in[8+i];
      endcase
    end
    return {oe, v};
  endfunction : exp_pins

  task automatic chk_port(input logic port2, input logic [7:0] fn, input logic [7:0] dir);
    logic [15:0] e;
    e = exp_pins(port2, fn, dir, port2 ? lat2 : lat1);
    if (port2) begin
      chk(snd_oe_n, e[15:8]);
      chk(snd_drv & ~e[15:8], e[7:0] & ~e[15:8]);
    end else begin
      chk(fst_oe_n, e[15:8]);
      chk(fst_drv & ~e[15:8], e[7:0] & ~e[15:8]);
    end
  endtask : chk_port

  initial begin
    lat1 = 8'h00;
    lat2 = 8'hff;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    settle();
    chk(fst_oe_n, 8'hff);
    chk(snd_oe_n, 8'hff);
    rd(dap_pkg::FIRST_PORT_DATA, ext1);
    rd(dap_pkg::SECOND_PORT_DATA, ext2);
    rd(16'h0002, 8'h00);
    // Latch reset values show once the pins turn to outputs
    wr(dap_pkg::FIRST_PORT_DIRECTION, 8'hff);
    wr(dap_pkg::SECOND_PORT_DIRECTION, 8'hff);
    settle();
    chk_port(1'b0, 8'h00, 8'hff);
    chk_port(1'b1, 8'h00, 8'hff);
    rd(dap_pkg::FIRST_PORT_DIRECTION, 8'h00);
    rd(dap_pkg::SECOND_PORT_DIRECTION, 8'h00);
    wr(dap_pkg::FIRST_PORT_DATA, 8'h3c);
    wr(dap_pkg::SECOND_PORT_DATA, 8'h96);
    wr(16'h0003, 8'hff);
    lat1 = 8'h3c;
    lat2 = 8'h96;
    settle();
    rd(dap_pkg::FIRST_PORT_DATA, 8'h3c);
    rd(dap_pkg::SECOND_PORT_DATA, 8'h96);
    // Direction before function on both ports, every pair value; pair 00 only on pins 0 and 4
    for (int k = 0; k < 4; k++) begin
      wr(dap_pkg::FIRST_PORT_DIRECTION, dir_tab[k]);
      wr(dap_pkg::FIRST_PORT_FUNCTION, fn_tab[k]);
      wr(dap_pkg::SECOND_PORT_DIRECTION, dir_tab[k]);
      wr(dap_pkg::SECOND_PORT_FUNCTION, fn_tab[k]);
      bus_ad_drive_in <= k[0];
      settle();
      chk_port(1'b0, fn_tab[k], dir_tab[k]);
      chk_port(1'b1, fn_tab[k], dir_tab[k]);
    end
    rd(dap_pkg::FIRST_PORT_FUNCTION, 8'h00);
    rd(dap_pkg::SECOND_PORT_FUNCTION, 8'h00);
    // Muxed data byte released: the pins read back what the far side drives
    wr(dap_pkg::FIRST_PORT_DIRECTION, 8'h00);
    wr(dap_pkg::FIRST_PORT_FUNCTION, 8'hff);
    bus_ad_drive_in <= 1'b0;
    settle();
    chk_port(1'b0, 8'hff, 8'h00);
    chk(bus_ad_rdata_out, ext1);
    @(posedge clk_in);
    bus_ad_drive_in <= 1'b1;
    settle();
    chk_port(1'b0, 8'hff, 8'h00);
    // Function set while direction is still clear: low address byte leaks out
    wr(dap_pkg::SECOND_PORT_FUNCTION, 8'h00);
    wr(dap_pkg::SECOND_PORT_DIRECTION, 8'h00);
    wr(dap_pkg::SECOND_PORT_FUNCTION, 8'hff);
    settle();
    chk_port(1'b1, 8'hff, 8'h00);
    @(posedge clk_in);
    bus_addr_in <= 24'hc8_e0f1;
    @(posedge clk_in);
    @(posedge clk_in);
    #1 chk_port(1'b1, 8'hff, 8'h00);
    wr(dap_pkg::SECOND_PORT_DIRECTION, 8'hff);
    settle();
    chk_port(1'b1, 8'hff, 8'hff);
    // Reset again in mid-run: configuration and latches return to their start
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    lat1 = 8'h00;
    lat2 = 8'hff;
    settle();
    chk(fst_oe_n, 8'hff);
    chk(snd_oe_n, 8'hff);
    wr(dap_pkg::FIRST_PORT_DIRECTION, 8'hff);
    wr(dap_pkg::SECOND_PORT_DIRECTION, 8'hff);
    settle();
    chk_port(1'b0, 8'h00, 8'hff);
    chk_port(1'b1, 8'h00, 8'hff);
    results();
  end

  initial begin
    #1000000;
    fail_count++;
    results();
  end
endmodule : dap_top_bench
